// [cdsc_consts.vh]
/*
 * Constants of the clock delay and sync configuration bank: register
 * indices, field positions, reset values, writable masks, code limits.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CDSC_CONSTS_VH
`define CDSC_CONSTS_VH

// Register indices; byte address is four times the index
`define CDSC_IDX_COARSE   6'h0C
`define CDSC_IDX_FINE     6'h0D
`define CDSC_IDX_SYNC     6'h0E
`define CDSC_IDX_RSVD     6'h0F
`define CDSC_IDX_STATUS   6'h10

// Reset values
`define CDSC_RST_COARSE   16'h0004
`define CDSC_RST_FINE     16'h0000
`define CDSC_RST_SYNC     16'h0003
`define CDSC_RST_RSVD     16'h000C

// Writable bits; reserved bits are not stored and read as zero
`define CDSC_WMASK_COARSE 16'hFFFC
`define CDSC_WMASK_FINE   16'hFDFF
`define CDSC_WMASK_SYNC   16'hFFDF

// Coarse delay word
`define CDSC_COARSE_HI    15
`define CDSC_COARSE_LO    4
`define CDSC_C_SEL        3
`define CDSC_C_DUTY       2

// Fine delay and filter word
`define CDSC_FINE_HI      15
`define CDSC_FINE_LO      10
`define CDSC_D_SEL        8
`define CDSC_TUNE_HI      7
`define CDSC_TUNE_LO      0

// Multi-chip sync word
`define CDSC_REFD_HI      15
`define CDSC_REFD_LO      6
`define CDSC_PHASE_HI     4
`define CDSC_PHASE_LO     3
`define CDSC_E_SLAVE      2
`define CDSC_E_OUTDIS     1
`define CDSC_E_RSTDIS     0

// Saturation limits of the delay codes
`define CDSC_COARSE_MAX   2431
`define CDSC_REFD_MAX     639

// AXI responses
`define CDSC_RESP_OKAY    2'h0
`define CDSC_RESP_DECERR  2'h3

`endif

// [cdsc_props.sv]
/* Checker of the config bank's decoded outputs.
   Assumes a bind onto cdsc_regs and no input change while CE is low. */
`timescale 1ns/10ps
module cdsc_props (
	input wire        SYS_CLK,
	input wire        RSTN,
	input wire        S_AXI_AWREADY,
	input wire        S_AXI_BVALID,
	input wire [11:0] COARSE_DELAY_CODE,
	input wire [5:0]  FINE_DELAY_CODE,
	input wire        APERTURE_DELAY_ENABLE,
	input wire        TANK_FILTER_ENABLE,
	input wire [7:0]  TANK_FILTER_TUNE,
	input wire [3:0]  TANK_FILTER_STEP,
	input wire [9:0]  REF_CLOCK_DELAY_CODE,
	input wire [1:0]  LATCH_PHASE_SELECT,
	input wire [3:0]  LATCH_PHASE_ONEHOT,
	input wire        REF_CLOCK_OUT_A,
	input wire        REF_CLOCK_OUT_B,
	input wire        DATA_CLOCK_RESET_INPUT,
	input wire        DATA_CLOCK_RESET_OUT
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	// Low half of the divided clock; a disable may stretch it, never cut it
	sequence s_low2;
		!REF_CLOCK_OUT_A [*2];
	endsequence
	a_coarse_clip: assert property (COARSE_DELAY_CODE <= 12'h97F)
		else $error("coarse code above limit");
	a_delay_gate: assert property (!APERTURE_DELAY_ENABLE |->
		COARSE_DELAY_CODE == 12'h0 && FINE_DELAY_CODE == 6'h0)
		else $error("delay codes pass while disabled");
	a_filter_sel: assert property (TANK_FILTER_ENABLE |->
		APERTURE_DELAY_ENABLE) else $error("filter without delay");
	a_tune_step: assert property (
		TANK_FILTER_STEP == $countones(TANK_FILTER_TUNE))
		else $error("tune step wrong");
	a_refd_clip: assert property (REF_CLOCK_DELAY_CODE <= 10'h27F)
		else $error("ref delay above limit");
	a_phase_hot: assert property (
		LATCH_PHASE_ONEHOT == (4'h1 << LATCH_PHASE_SELECT))
		else $error("phase one-hot wrong");
	a_refout_pair: assert property (REF_CLOCK_OUT_A == REF_CLOCK_OUT_B)
		else $error("ref outputs differ");
	a_refout_low: assert property ($fell(REF_CLOCK_OUT_A) |-> s_low2)
		else $error("ref clock low phase short");
	a_dclk_cause: assert property (DATA_CLOCK_RESET_OUT |->
		$past(DATA_CLOCK_RESET_INPUT)) else $error("reset out without cause");
	a_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("address ready during response");
endmodule
bind cdsc_regs cdsc_props u_cdsc_props (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.COARSE_DELAY_CODE(COARSE_DELAY_CODE), .FINE_DELAY_CODE(FINE_DELAY_CODE),
	.APERTURE_DELAY_ENABLE(APERTURE_DELAY_ENABLE),
	.TANK_FILTER_ENABLE(TANK_FILTER_ENABLE),
	.TANK_FILTER_TUNE(TANK_FILTER_TUNE), .TANK_FILTER_STEP(TANK_FILTER_STEP),
	.REF_CLOCK_DELAY_CODE(REF_CLOCK_DELAY_CODE),
	.LATCH_PHASE_SELECT(LATCH_PHASE_SELECT),
	.LATCH_PHASE_ONEHOT(LATCH_PHASE_ONEHOT),
	.REF_CLOCK_OUT_A(REF_CLOCK_OUT_A), .REF_CLOCK_OUT_B(REF_CLOCK_OUT_B),
	.DATA_CLOCK_RESET_INPUT(DATA_CLOCK_RESET_INPUT),
	.DATA_CLOCK_RESET_OUT(DATA_CLOCK_RESET_OUT));

// [cdsc_regs.v]
/*
 * Clock delay, clock filter and multi-chip sync configuration bank
 * behind an AXI4-Lite slave, with the decoded control outputs.
 * Assumes one clock SYS_CLK, synchronous active-low RSTN, and inputs
 * synchronous to SYS_CLK; CE low freezes every flip-flop.
 */
`timescale 1ns/10ps
`include "cdsc_consts.vh"

module cdsc_regs #(
	parameter ADDR_W   = 8,
	parameter COARSE_W = 12,
	parameter FINE_W   = 6,
	parameter TUNE_W   = 8,
	parameter REFD_W   = 10
) (
	input  wire                SYS_CLK,
	input  wire                RSTN,
	input  wire                CE,
	input  wire [ADDR_W-1:0]   S_AXI_AWADDR,
	input  wire                S_AXI_AWVALID,
	output reg                 S_AXI_AWREADY,
	input  wire [31:0]         S_AXI_WDATA,
	input  wire [3:0]          S_AXI_WSTRB,
	input  wire                S_AXI_WVALID,
	output reg                 S_AXI_WREADY,
	output reg  [1:0]          S_AXI_BRESP,
	output reg                 S_AXI_BVALID,
	input  wire                S_AXI_BREADY,
	input  wire [ADDR_W-1:0]   S_AXI_ARADDR,
	input  wire                S_AXI_ARVALID,
	output reg                 S_AXI_ARREADY,
	output reg  [31:0]         S_AXI_RDATA,
	output reg  [1:0]          S_AXI_RRESP,
	output reg                 S_AXI_RVALID,
	input  wire                S_AXI_RREADY,
	input  wire                DATA_CLOCK_RESET_INPUT,
	output wire [COARSE_W-1:0] COARSE_DELAY_CODE,
	output reg  [FINE_W-1:0]   FINE_DELAY_CODE,
	output reg                 APERTURE_DELAY_ENABLE,
	output reg                 TANK_FILTER_ENABLE,
	output reg  [TUNE_W-1:0]   TANK_FILTER_TUNE,
	output reg  [3:0]          TANK_FILTER_STEP,
	output reg                 DUTY_CYCLE_FIX_ENABLE,
	output wire [REFD_W-1:0]   REF_CLOCK_DELAY_CODE,
	output reg  [1:0]          LATCH_PHASE_SELECT,
	output reg  [3:0]          LATCH_PHASE_ONEHOT,
	output reg                 SLAVE_MODE_ENABLE,
	output reg                 REF_CLOCK_OUT_A,
	output reg                 REF_CLOCK_OUT_B,
	output reg                 DATA_CLOCK_RESET_OUT
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	reg  [15:0]         coarse_reg;
	reg  [15:0]         fine_reg;
	reg  [15:0]         sync_reg;
	reg  [ADDR_W-1:0]   aw_addr;
	reg  [31:0]         w_data;
	reg  [3:0]          w_strb;
	reg  [31:0]         next_rdata;
	reg  [1:0]          next_rresp;
	reg  [3:0]          ones;
	reg  [1:0]          div_cnt;
	reg                 tune_valid;
	wire                do_write;
	wire                wr_hit;
	wire [5:0]          aw_idx;
	wire [5:0]          ar_idx;
	wire                delay_sel;
	wire                filter_sel;
	wire                delay_en;
	wire                coarse_sat;
	wire                refd_sat;
	wire [TUNE_W-1:0]   tune_code;
	wire [TUNE_W-1:0]   tune_inc;
	wire [COARSE_W-1:0] coarse_code;
	wire [REFD_W-1:0]   refd_code;
	wire [31:0]         status_word;
	integer             i;

	////////////////////////////////////////////////////////////////////
	// Byte-lane merge; reserved bits are dropped so they read as zero

	function [15:0] merge;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		input [15:0] wmask;
		reg   [15:0] lane;
		begin
			lane  = {{8{strb[1]}}, {8{strb[0]}}};
			merge = ((old & ~lane) | (data[15:0] & lane)) & wmask;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// AXI write channel
	// Address and data are taken in either order; one write in flight.

	assign aw_idx   = aw_addr[ADDR_W-1:2];
	assign do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
	assign wr_hit   = (aw_idx == `CDSC_IDX_COARSE) ||
	                  (aw_idx == `CDSC_IDX_FINE) ||
	                  (aw_idx == `CDSC_IDX_SYNC) ||
	                  (aw_idx == `CDSC_IDX_RSVD) ||
	                  (aw_idx == `CDSC_IDX_STATUS);

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `CDSC_RESP_OKAY;
			aw_addr       <= {ADDR_W{1'b0}};
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
		end else if (CE) begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_addr       <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_data       <= S_AXI_WDATA;
				w_strb       <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_hit ? `CDSC_RESP_OKAY :
				                `CDSC_RESP_DECERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration registers
	// Reserved and status words take writes with OKAY but keep nothing.

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			coarse_reg <= `CDSC_RST_COARSE;
			fine_reg   <= `CDSC_RST_FINE;
			sync_reg   <= `CDSC_RST_SYNC;
		end else if (CE && do_write) begin
			case (aw_idx)
			`CDSC_IDX_COARSE: begin
				coarse_reg <= merge(coarse_reg, w_data, w_strb,
				                    `CDSC_WMASK_COARSE);
			end
			`CDSC_IDX_FINE: begin
				fine_reg <= merge(fine_reg, w_data, w_strb,
				                  `CDSC_WMASK_FINE);
			end
			`CDSC_IDX_SYNC: begin
				sync_reg <= merge(sync_reg, w_data, w_strb,
				                  `CDSC_WMASK_SYNC);
			end
			default: begin
				coarse_reg <= coarse_reg;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI read channel

	assign ar_idx = S_AXI_ARADDR[ADDR_W-1:2];

	always @* begin
		next_rresp = `CDSC_RESP_OKAY;
		case (ar_idx)
		`CDSC_IDX_COARSE: begin
			next_rdata = {16'h0000, coarse_reg};
		end
		`CDSC_IDX_FINE: begin
			next_rdata = {16'h0000, fine_reg};
		end
		`CDSC_IDX_SYNC: begin
			next_rdata = {16'h0000, sync_reg};
		end
		`CDSC_IDX_RSVD: begin
			next_rdata = {16'h0000, `CDSC_RST_RSVD};
		end
		`CDSC_IDX_STATUS: begin
			next_rdata = status_word;
		end
		default: begin
			next_rdata = 32'h00000000;
			next_rresp = `CDSC_RESP_DECERR;
		end
		endcase
	end

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h00000000;
			S_AXI_RRESP   <= `CDSC_RESP_OKAY;
		end else if (CE) begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RDATA   <= next_rdata;
				S_AXI_RRESP   <= next_rresp;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_ARREADY <= 1'b0;
			end
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Aperture delay decode

	assign delay_sel   = coarse_reg[`CDSC_C_SEL];
	assign filter_sel  = fine_reg[`CDSC_D_SEL];
	// Filter select alone is enough, whatever the coarse select holds
	assign delay_en    = filter_sel | delay_sel;
	assign coarse_code = coarse_reg[`CDSC_COARSE_HI:`CDSC_COARSE_LO];

	cdsc_sat #(
		.W   (COARSE_W),
		.MAX (`CDSC_COARSE_MAX)
	) u_coarse_sat (
		.clk      (SYS_CLK),
		.rstn     (RSTN),
		.ce       (CE),
		.en       (delay_en),
		.code     (coarse_code),
		.code_out (COARSE_DELAY_CODE),
		.sat      (coarse_sat)
	);

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			FINE_DELAY_CODE       <= {FINE_W{1'b0}};
			APERTURE_DELAY_ENABLE <= 1'b0;
			DUTY_CYCLE_FIX_ENABLE <= 1'b1;
		end else if (CE) begin
			FINE_DELAY_CODE <= delay_en ?
				fine_reg[`CDSC_FINE_HI:`CDSC_FINE_LO] :
				{FINE_W{1'b0}};
			APERTURE_DELAY_ENABLE <= delay_en;
			DUTY_CYCLE_FIX_ENABLE <= coarse_reg[`CDSC_C_DUTY];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Tank filter tuning
	// Code is a thermometer: the step count is the number of ones.
	// Non-thermometer codes still pass; the status word flags them.

	assign tune_code = fine_reg[`CDSC_TUNE_HI:`CDSC_TUNE_LO];
	assign tune_inc  = tune_code + {{(TUNE_W-1){1'b0}}, 1'b1};

	always @* begin
		ones = 4'h0;
		for (i = 0; i < TUNE_W; i = i + 1) begin
			ones = ones + {3'h0, tune_code[i]};
		end
		tune_valid = ((tune_code & tune_inc) == {TUNE_W{1'b0}});
	end

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			TANK_FILTER_ENABLE <= 1'b0;
			TANK_FILTER_TUNE   <= {TUNE_W{1'b0}};
			TANK_FILTER_STEP   <= 4'h0;
		end else if (CE) begin
			TANK_FILTER_ENABLE <= filter_sel;
			TANK_FILTER_TUNE   <= tune_code;
			TANK_FILTER_STEP   <= ones;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Multi-chip sync decode

	assign refd_code = sync_reg[`CDSC_REFD_HI:`CDSC_REFD_LO];

	cdsc_sat #(
		.W   (REFD_W),
		.MAX (`CDSC_REFD_MAX)
	) u_refd_sat (
		.clk      (SYS_CLK),
		.rstn     (RSTN),
		.ce       (CE),
		.en       (1'b1),
		.code     (refd_code),
		.code_out (REF_CLOCK_DELAY_CODE),
		.sat      (refd_sat)
	);

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			LATCH_PHASE_SELECT <= 2'h0;
			LATCH_PHASE_ONEHOT <= 4'h1;
			SLAVE_MODE_ENABLE  <= 1'b0;
		end else if (CE) begin
			LATCH_PHASE_SELECT <=
				sync_reg[`CDSC_PHASE_HI:`CDSC_PHASE_LO];
			LATCH_PHASE_ONEHOT <= 4'h1 <<
				sync_reg[`CDSC_PHASE_HI:`CDSC_PHASE_LO];
			SLAVE_MODE_ENABLE  <= sync_reg[`CDSC_E_SLAVE];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reference clock outputs
	// Divider runs free in both modes; enabling it takes effect on the next clock
	// and may cut the first high phase short; outputs are quarter rate of the gated clock.

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			div_cnt         <= 2'h0;
			REF_CLOCK_OUT_A <= 1'b0;
			REF_CLOCK_OUT_B <= 1'b0;
		end else if (CE) begin
			div_cnt         <= div_cnt + 2'h1;
			REF_CLOCK_OUT_A <= !sync_reg[`CDSC_E_OUTDIS] &
			                   div_cnt[1];
			REF_CLOCK_OUT_B <= !sync_reg[`CDSC_E_OUTDIS] &
			                   div_cnt[1];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data clock reset gate

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			DATA_CLOCK_RESET_OUT <= 1'b0;
		end else if (CE) begin
			DATA_CLOCK_RESET_OUT <= DATA_CLOCK_RESET_INPUT &
			                        !sync_reg[`CDSC_E_RSTDIS];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status word, read only

	assign status_word = {26'h0000000, !tune_valid, refd_sat, coarse_sat,
	                      SLAVE_MODE_ENABLE, TANK_FILTER_ENABLE,
	                      APERTURE_DELAY_ENABLE};

endmodule

// [cdsc_sat.v]
/*
 * Saturating, gated code register: output is the code clipped to MAX
 * while enabled, zero otherwise, plus a flag while enabled and the code is at or above MAX.
 * Assumes a synchronous active-low reset and a clock enable.
 */
`timescale 1ns/10ps

module cdsc_sat #(
	parameter W   = 12,
	parameter MAX = 2431
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire         ce,
	input  wire         en,
	input  wire [W-1:0] code,
	output reg  [W-1:0] code_out,
	output reg          sat
);

	localparam [W-1:0] LIMIT = MAX[W-1:0];

	wire over;

	assign over = (code >= LIMIT);

	always @(posedge clk) begin
		if (!rstn) begin
			code_out <= {W{1'b0}};
			sat      <= 1'b0;
		end else if (ce) begin
			if (!en) begin
				code_out <= {W{1'b0}};
				sat      <= 1'b0;
			end else if (over) begin
				code_out <= LIMIT;
				sat      <= 1'b1;
			end else begin
				code_out <= code;
				sat      <= 1'b0;
			end
		end
	end

endmodule

// [tb.sv]
/* Self-checking bench of the config bank over AXI4-Lite.
   Assumes the bound checker; CE drops once, with no bus traffic. */
`timescale 1ns/10ps
module tb;
	logic        SYS_CLK = 1'b0;
	logic        RSTN = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, r, seed = 32'h075BECED;
	logic [3:0]  wstrb = 4'hF;
	logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0;
	logic        arv = 1'b0, rrdy = 1'b0, dcin = 1'b0, ce = 1'b1;
	logic [1:0]  resp;
	logic [15:0] m [12:14];
	logic [11:0] ctab [4] = '{12'h97E, 12'h97F, 12'h980, 12'hFFF};
	logic [9:0]  rtab [4] = '{10'h27E, 10'h27F, 10'h280, 10'h3FF};
	logic [15:0] rsv [3] = '{16'hFFFC, 16'hFDFF, 16'hFFDF};
	wire         awr, wrdy, bv, arr, rv, aen, fen, duty, slv, ra, rb, dco;
	wire  [1:0]  bresp, rresp, ph;
	wire  [31:0] rdat;
	wire  [11:0] coarse;
	wire  [5:0]  fine;
	wire  [7:0]  tune;
	wire  [3:0]  step, oh;
	wire  [9:0]  refd;
	int          num_errors = 0, compares = 0, n, k;

	cdsc_regs u_cdsc_regs (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(ce),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(brdy), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .DATA_CLOCK_RESET_INPUT(dcin),
		.COARSE_DELAY_CODE(coarse), .FINE_DELAY_CODE(fine),
		.APERTURE_DELAY_ENABLE(aen), .TANK_FILTER_ENABLE(fen),
		.TANK_FILTER_TUNE(tune), .TANK_FILTER_STEP(step),
		.DUTY_CYCLE_FIX_ENABLE(duty), .REF_CLOCK_DELAY_CODE(refd),
		.LATCH_PHASE_SELECT(ph), .LATCH_PHASE_ONEHOT(oh),
		.SLAVE_MODE_ENABLE(slv), .REF_CLOCK_OUT_A(ra), .REF_CLOCK_OUT_B(rb),
		.DATA_CLOCK_RESET_OUT(dco));

	always #10 SYS_CLK = ~SYS_CLK;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
	endfunction
	function automatic logic [31:0] clip(input logic [31:0] v, lim);
		return v > lim ? lim : v;
	endfunction
	// A thermometer code with n ones is the n lowest bits set
	function automatic logic odd_tune(input logic [7:0] v);
		return v != (8'hFF >> (8 - $countones(v)));
	endfunction
	task automatic chk(input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Entered just after a rising edge; sampled at the falling edge
	task automatic wr(input logic [5:0] i, input logic [31:0] d,
		input logic [3:0] s);
		logic ta, tw, tv;
		logic [15:0] bm;
		bm = {{8{s[1]}}, {8{s[0]}}};
		if (i >= 12 && i <= 14) m[i] = (m[i] & ~bm) | (d[15:0] & bm);
		awaddr <= {i, 2'b00};
		wdata <= d;
		wstrb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do begin
			@(negedge SYS_CLK);
			ta = awv & awr;
			tw = wv & wrdy;
			tv = bv;
			resp = bresp;
			@(posedge SYS_CLK);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tv);
		// Ready stays up; dropping it would clash with a following call
	endtask
	task automatic rd(input logic [5:0] i);
		logic ta, tv;
		araddr <= {i, 2'b00};
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(negedge SYS_CLK);
			ta = arv & arr;
			tv = rv;
			r = rdat;
			resp = rresp;
			@(posedge SYS_CLK);
			if (ta) arv <= 1'b0;
		end while (!tv);
		// Ready stays up for the same reason
	endtask
	task automatic chkall;
		logic [15:0] c, d, e;
		logic en;
		logic [31:0] st;
		c = m[12];
		d = m[13];
		e = m[14];
		en = c[3] | d[8];
		st = {26'h0000000, odd_tune(d[7:0]), e[15:6] >= 639,
		      en && c[15:4] >= 2431, e[2], d[8], en};
		repeat (2) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk(aen, en);
		chk(coarse, en ? clip(c[15:4], 2431) : 0);
		chk(fine, en ? d[15:10] : 0);
		chk(fen, d[8]);
		chk(tune, d[7:0]);
		chk(step, $countones(d[7:0]));
		chk(duty, c[2]);
		chk(refd, clip(e[15:6], 639));
		chk(ph, e[4:3]);
		chk(slv, e[2]);
		chk(oh, 1 << e[4:3]);
		chk(dco, dcin & !e[0]);
		if (e[1]) chk(ra | rb, 0);
		chk(rb, ra);
		@(posedge SYS_CLK);
		for (int j = 12; j < 15; j++) begin
			rd(6'(j));
			chk(r, m[j]);
		end
		rd(6'h10);
		chk(r, st);
	endtask

	initial begin
		#400000;
		num_errors++;
		end_of_test;
	end
	initial begin
		m[12] = 16'h0004;
		m[13] = 16'h0000;
		m[14] = 16'h0003;
		repeat (4) @(posedge SYS_CLK);
		RSTN <= 1'b1;
		@(posedge SYS_CLK);
		chkall;
		rd(6'h0F);
		chk(r, 32'h000C);
		$display("test reset done");
		foreach (ctab[j]) for (int s = 0; s < 3; s++) begin
			wr(6'h0C, {ctab[j], s == 0, 3'b100}, 4'hF);
			wr(6'h0D, {6'h3F, 1'b0, s == 1, 8'h0F}, 4'hF);
			chkall;
		end
		$display("test coarse done");
		for (k = 0; k < 4; k++) begin
			dcin <= k[0];
			wr(6'h0E, {rtab[k], 1'b0, k[1:0], k[0], 1'b1, k[1]}, 4'hF);
			chkall;
		end
		$display("test sync done");
		wr(6'h0E, 32'h0, 4'hF);
		repeat (2) @(posedge SYS_CLK);
		n = 0;
		repeat (8) begin
			@(negedge SYS_CLK);
			n += ra;
		end
		chk(n, 4);
		@(posedge SYS_CLK);
		ce <= 1'b0;
		@(negedge SYS_CLK);
		k = ra;
		// Divider must hold its phase while the enable is low
		repeat (4) begin
			@(negedge SYS_CLK);
			chk(ra, k);
		end
		@(posedge SYS_CLK);
		ce <= 1'b1;
		@(posedge SYS_CLK);
		wr(6'h0E, 32'h3, 4'hF);
		$display("test refout done");
		wr(6'h0C, 32'hABC8, 4'h1);
		chkall;
		rd(6'h20);
		chk({r[29:0], resp}, 32'h3);
		wr(6'h20, 32'hFFFF, 4'hF);
		chk(resp, 2'h3);
		wr(6'h0F, 32'hFFFF, 4'hF);
		chk(resp, 2'h0);
		rd(6'h0F);
		chk(r, 32'h000C);
		$display("test bus done");
		repeat (30) begin
			seed = lfsr(seed);
			k = seed[5:4] % 3;
			dcin <= seed[8];
			wr(6'(12 + k), seed & {16'h0, rsv[k]}, seed[31:28]);
			chkall;
		end
		$display("test random done");
		end_of_test;
	end
endmodule
